// ==== core/ccu_pkg.sv ====
/*
 Constants shared by the capture/compare unit: register map, field layout,
 channel modes and timing figures. Assumes a 20 MHz pclk.
*/
package ccu_pkg;
   // Register byte offsets
   localparam logic [11:0] OFS_VALUE     = 12'h000;   // 32 channel value words
   localparam logic [11:0] OFS_CHAN_CTRL = 12'h080;   // 32 channel control words
   localparam logic [11:0] OFS_STAT_CH   = 12'h100;
   localparam logic [11:0] OFS_STAT_TM   = 12'h104;
   localparam logic [11:0] OFS_CLR_CH    = 12'h108;
   localparam logic [11:0] OFS_CLR_TM    = 12'h10C;
   localparam logic [11:0] OFS_EN_CH     = 12'h110;
   localparam logic [11:0] OFS_EN_TM     = 12'h114;
   localparam logic [11:0] OFS_TMR_CTRL  = 12'h120;   // 4 timer control words
   localparam logic [11:0] OFS_TMR_RELD  = 12'h130;   // 4 reload words
   localparam logic [11:0] OFS_TMR_CNT   = 12'h140;   // 4 count words
   localparam logic [11:0] OFS_END       = 12'h150;

   // Channel control fields
   localparam int CH_MODE_LSB = 0;    // 3 bits
   localparam int CH_TSEL_BIT = 3;
   localparam int CH_RISE_BIT = 4;
   localparam int CH_FALL_BIT = 5;
   localparam int PRIO_LSB    = 8;    // 4 bits, channel and timer words alike
   // Timer control fields
   localparam int TM_CSEL_LSB = 0;    // 3 bits
   localparam int TM_EXT_BIT  = 3;
   localparam int TM_RUN_BIT  = 4;
   localparam logic [11:0] CTRL_MASK = 12'hF3F;

   // Channel modes, then the timer count select for general timer six
   localparam logic [2:0] MODE_OFF  = 3'h0;
   localparam logic [2:0] MODE_CAPT = 3'h1;
   localparam logic [2:0] MODE_CMP0 = 3'h2;
   localparam logic [2:0] MODE_CMP1 = 3'h3;
   localparam logic [2:0] MODE_CMP2 = 3'h4;
   localparam logic [2:0] MODE_CMP3 = 3'h5;
   localparam logic [2:0] MODE_DBL  = 3'h6;
   localparam logic [2:0] CSEL_GEN6 = 3'h7;   // count on general timer six overflow

   localparam int NUM_CH   = 32;
   localparam int NUM_TMR  = 4;
   localparam int CLK_NS   = 50;
   localparam int RES_NS   = 400;
   localparam int BASE_DIV = (RES_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [15:0] CNT_TOP  = 16'hFFFF;
   localparam logic [11:0] CTRL_RST = 12'h000;
endpackage : ccu_pkg

// ==== core/ccu_timer.sv ====
/*
 One 16-bit timer with reload, prescaler and count source select.
 Assumes ext_in and gen_tick are synchronous to pclk.
*/
`timescale 1ns/1ns
`default_nettype none
module ccu_timer
   import ccu_pkg::*;
(
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // Control
   input  wire logic        run,
   input  wire logic [2:0]  clk_sel,
   input  wire logic        ext_en,
   input  wire logic        ext_in,
   input  wire logic        gen_tick,
   input  wire logic [15:0] reload,
   input  wire logic        load,
   input  wire logic [15:0] load_val,
   // Timer state
   output logic      [15:0] cnt,
   output logic             ovf,
   output logic             step
);
   logic [9:0] presc_r;
   logic [9:0] div_m1;
   logic       ext_prev_r;
   logic       tick;

   assign div_m1 = 10'((BASE_DIV << clk_sel) - 1);
   always_comb begin
      if (ext_en)
         tick = run & ext_in & ~ext_prev_r;
      else if (clk_sel == CSEL_GEN6)
         tick = run & gen_tick;
      else
         tick = run & (presc_r == div_m1);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         presc_r    <= 10'h000;
         ext_prev_r <= 1'b0;
      end else begin
         ext_prev_r <= ext_in;
         // Wraps early if the selection shrinks mid-count
         presc_r    <= (presc_r >= div_m1) ? 10'h000 : presc_r + 10'h001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt  <= 16'h0000;
         ovf  <= 1'b0;
         step <= 1'b0;
      end else begin
         ovf  <= 1'b0;
         step <= tick & ~load;
         if (load)
            cnt <= load_val;
         else if (tick) begin
            if (cnt == CNT_TOP) begin
               cnt <= reload;
               ovf <= 1'b1;
            end else
               cnt <= cnt + 16'h0001;
         end
      end
   end

   a_reload_on_wrap: assert property (@(posedge pclk) disable iff (!presetn)
      tick && !load && cnt == CNT_TOP |=> cnt == $past(reload) && ovf && step)
      else $error("timer did not reload on overflow");
endmodule : ccu_timer
`default_nettype wire

// ==== core/ccu_top.sv ====
/*
 Capture/compare unit: two arrays of 16 channels, four reloadable timers,
 APB register slave and one level interrupt. Assumes pins are synchronous
 to pclk and the APB master follows the standard two-phase protocol.
*/
// The placing of the registers and the APB register port were decided locally.
// What this block does
// - Offer 32 channels timing events down to 400 ns at 20 MHz.
// - Four 16-bit reloadable timers, one pair per channel array.
// - Timer count clock is a software prescale choice or timer six overflows.
// - First timer of each pair may count external input edges.
// - Each of 16 channels per array picks its timer and capture or compare.
// - Each channel owns a pin; channels 24 to 27 are input only.
// - Capture copies the assigned count into the channel and flags its interrupt.
// - Capture edge selectable: rising, falling or both.
// - Compare channels match continuously against their timer and act by mode.
// - Mode 0 flags an interrupt on every match, pin untouched.
// - Mode 1 toggles the pin on every match.
// - Mode 2 flags at most one interrupt per timer period.
// - Mode 3 sets pin on match, clears it on overflow, once per period.
// - Double mode: two channels toggle one pin on either match.
// - Every channel and timer has request flag, enable flag and priority field.
`timescale 1ns/1ns
`default_nettype none
module ccu_top
   import ccu_pkg::*;
(
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Channel pins
   input  wire logic [31:0] cc_pin_in,
   output logic      [31:0] cc_pin_out,
   output logic      [31:0] cc_pin_oe,
   // Count sources
   input  wire logic        array_a_timer_first_ext_in,
   input  wire logic        array_b_timer_first_ext_in,
   input  wire logic        general_timer_six_tick,
   // Interrupt
   output logic             irq
);
   logic [15:0] val_r   [NUM_CH];
   logic [11:0] ctrl_r  [NUM_CH];
   logic [11:0] tctrl_r [NUM_TMR];
   logic [15:0] reld_r  [NUM_TMR];
   logic [15:0] cnt     [NUM_TMR];
   logic [3:0]  ovf;
   logic [3:0]  step;
   logic [3:0]  tload;
   logic [1:0]  ext_in;
   logic [31:0] st_ch_r, en_ch_r;
   logic [3:0]  st_tm_r, en_tm_r;
   logic [31:0] pin_prev_r, fired_r;
   logic [31:0] cap_ev, hit, upper_dbl, ch_set, tog, fired_nxt;
   logic [1:0]  tsel [NUM_CH];
   logic [31:0] rdata_nxt;
   logic        err_nxt, wr_go, rd_go;

   function automatic logic [2:0] mode_of(input logic [11:0] c);
      return c[CH_MODE_LSB +: 3];
   endfunction : mode_of

   // Byte address of word n in a block starting at base
   function automatic logic [11:0] wa(input logic [11:0] base, input int n);
      return base + 12'(n * 4);
   endfunction : wa

   // Zero wait states would need a combinational prdata; one wait keeps it registered
   assign rd_go = psel & penable & ~pready;
   assign wr_go = psel & penable & pready & pwrite;

   assign ext_in = {array_b_timer_first_ext_in, array_a_timer_first_ext_in};
   for (genvar t = 0; t < NUM_TMR; t++) begin : g_tmr
      ccu_timer u_tmr (
         .pclk     (pclk),
         .presetn  (presetn),
         .run      (tctrl_r[t][TM_RUN_BIT]),
         .clk_sel  (tctrl_r[t][TM_CSEL_LSB +: 3]),
         .ext_en   ((t % 2 == 0) ? tctrl_r[t][TM_EXT_BIT] : 1'b0),
         .ext_in   (ext_in[t/2]),
         .gen_tick (general_timer_six_tick),
         .reload   (reld_r[t]),
         .load     (tload[t]),
         .load_val (pwdata[15:0]),
         .cnt      (cnt[t]),
         .ovf      (ovf[t]),
         .step     (step[t])
      );
      assign tload[t] = wr_go && paddr == wa(OFS_TMR_CNT, t);
   end

   // Channel event logic
   always_comb begin
      for (int j = 0; j < NUM_CH; j++) begin
         upper_dbl[j] = (j % 16 >= 8)
                        && mode_of(ctrl_r[(j + NUM_CH - 8) % NUM_CH]) == MODE_DBL;
         // Upper half of a double pair follows the lower channel's timer
         tsel[j] = {1'(j / 16), upper_dbl[j] ? ctrl_r[(j + NUM_CH - 8) % NUM_CH][CH_TSEL_BIT]
                                              : ctrl_r[j][CH_TSEL_BIT]};
         cap_ev[j] = !upper_dbl[j] && mode_of(ctrl_r[j]) == MODE_CAPT
                     && ((ctrl_r[j][CH_RISE_BIT] && cc_pin_in[j] && !pin_prev_r[j])
                     || (ctrl_r[j][CH_FALL_BIT] && !cc_pin_in[j] && pin_prev_r[j]));
         hit[j] = (upper_dbl[j] || mode_of(ctrl_r[j]) >= MODE_CMP0)
                  && step[tsel[j]] && cnt[tsel[j]] == val_r[j];
      end
      // Second pass, so a lower double channel sees its partner's match this cycle
      for (int j = 0; j < NUM_CH; j++) begin
         fired_nxt[j] = fired_r[j];
         if (ovf[tsel[j]])
            fired_nxt[j] = 1'b0;
         ch_set[j] = cap_ev[j];
         tog[j] = 1'b0;
         if (upper_dbl[j])
            ch_set[j] = hit[j];
         else
            case (mode_of(ctrl_r[j]))
               MODE_CMP0: ch_set[j] = hit[j];
               MODE_CMP1, MODE_DBL: begin
                  ch_set[j] = hit[j];
                  tog[j] = hit[j] || (mode_of(ctrl_r[j]) == MODE_DBL
                           && j % 16 < 8 && hit[(j+8) % NUM_CH]);
               end
               MODE_CMP2, MODE_CMP3: begin
                  ch_set[j] = hit[j] && !fired_nxt[j];
                  if (hit[j])
                     fired_nxt[j] = 1'b1;
               end
               default: ;
            endcase
      end
   end

   // Channel registers and pins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int j = 0; j < NUM_CH; j++) begin
            val_r[j]  <= 16'h0000;
            ctrl_r[j] <= CTRL_RST;
         end
         pin_prev_r <= 32'h0000_0000;
         fired_r    <= 32'h0000_0000;
         cc_pin_out <= 32'h0000_0000;
         cc_pin_oe  <= 32'h0000_0000;
      end else begin
         pin_prev_r <= cc_pin_in;
         fired_r    <= fired_nxt;
         for (int j = 0; j < NUM_CH; j++) begin
            if (wr_go && paddr == wa(OFS_CHAN_CTRL, j))
               ctrl_r[j] <= pwdata[11:0] & CTRL_MASK;
            // A capture outranks a software write in the same cycle
            if (cap_ev[j])
               val_r[j] <= cnt[tsel[j]];
            else if (wr_go && paddr == wa(OFS_VALUE, j))
               val_r[j] <= pwdata[15:0];
            if (j >= 24 && j <= 27) begin
               cc_pin_out[j] <= 1'b0;
               cc_pin_oe[j]  <= 1'b0;
            end else begin
               cc_pin_oe[j] <= !upper_dbl[j] && (mode_of(ctrl_r[j]) == MODE_CMP1
                               || mode_of(ctrl_r[j]) == MODE_CMP3
                               || mode_of(ctrl_r[j]) == MODE_DBL);
               if (tog[j])
                  cc_pin_out[j] <= ~cc_pin_out[j];
               else if (!upper_dbl[j] && mode_of(ctrl_r[j]) == MODE_CMP3) begin
                  if (ch_set[j])
                     cc_pin_out[j] <= 1'b1;
                  else if (ovf[tsel[j]])
                     cc_pin_out[j] <= 1'b0;
               end
            end
         end
      end
   end

   // Timer control and reload words
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int t = 0; t < NUM_TMR; t++) begin
            tctrl_r[t] <= CTRL_RST;
            reld_r[t]  <= 16'h0000;
         end
      end else begin
         for (int t = 0; t < NUM_TMR; t++) begin
            if (wr_go && paddr == wa(OFS_TMR_CTRL, t))
               tctrl_r[t] <= pwdata[11:0] & CTRL_MASK;
            if (wr_go && paddr == wa(OFS_TMR_RELD, t))
               reld_r[t] <= pwdata[15:0];
         end
      end
   end

   // Sticky flags: a new event wins over a clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ch_r <= 32'h0000_0000;
         st_tm_r <= 4'h0;
         en_ch_r <= 32'h0000_0000;
         en_tm_r <= 4'h0;
         irq     <= 1'b0;
      end else begin
         st_ch_r <= (st_ch_r & ~((wr_go && paddr == OFS_CLR_CH) ? pwdata : 32'h0000_0000))
                    | ch_set;
         st_tm_r <= (st_tm_r & ~((wr_go && paddr == OFS_CLR_TM) ? pwdata[3:0] : 4'h0))
                    | ovf;
         if (wr_go && paddr == OFS_EN_CH)
            en_ch_r <= pwdata;
         if (wr_go && paddr == OFS_EN_TM)
            en_tm_r <= pwdata[3:0];
         irq <= |(st_ch_r & en_ch_r) | |(st_tm_r & en_tm_r);
      end
   end

   // Read mux and unmapped-address detection
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      err_nxt   = paddr[1:0] != 2'h0 || paddr >= OFS_END
                  || (paddr >= 12'h118 && paddr < OFS_TMR_CTRL);
      for (int j = 0; j < NUM_CH; j++) begin
         if (paddr == wa(OFS_VALUE, j))
            rdata_nxt = {16'h0000, val_r[j]};
         if (paddr == wa(OFS_CHAN_CTRL, j))
            rdata_nxt = {20'h00000, ctrl_r[j]};
      end
      for (int t = 0; t < NUM_TMR; t++) begin
         if (paddr == wa(OFS_TMR_CTRL, t))
            rdata_nxt = {20'h00000, tctrl_r[t]};
         if (paddr == wa(OFS_TMR_RELD, t))
            rdata_nxt = {16'h0000, reld_r[t]};
         if (paddr == wa(OFS_TMR_CNT, t))
            rdata_nxt = {16'h0000, cnt[t]};
      end
      case (paddr)
         OFS_STAT_CH: rdata_nxt = st_ch_r;
         OFS_STAT_TM: rdata_nxt = {28'h0000000, st_tm_r};
         OFS_EN_CH:   rdata_nxt = en_ch_r;
         OFS_EN_TM:   rdata_nxt = {28'h0000000, en_tm_r};
         default: ;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= rd_go;
         pslverr <= rd_go & err_nxt;
         if (rd_go)
            prdata <= pwrite ? 32'h0000_0000 : rdata_nxt;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_capture_copies_count: assert property (cap_ev[1] |=> val_r[1] == $past(cnt[tsel[1]]))
      else $error("capture did not copy timer count");
   a_capture_raises_flag: assert property (cap_ev[1] |=> st_ch_r[1])
      else $error("capture did not set request flag");
   a_capture_edge_kind: assert property (cap_ev[1] && !ctrl_r[1][CH_FALL_BIT]
      |-> cc_pin_in[1] && !pin_prev_r[1])
      else $error("capture on unselected edge");
   a_mode0_flags_match: assert property (hit[6] && mode_of(ctrl_r[6]) == MODE_CMP0
      |=> st_ch_r[6] && $stable(cc_pin_out[6]))
      else $error("mode 0 match mishandled");
   a_mode1_pin_toggle: assert property (tog[2] |=> cc_pin_out[2] != $past(cc_pin_out[2]))
      else $error("mode 1 pin did not toggle");
   a_mode2_single_flag: assert property (mode_of(ctrl_r[6]) == MODE_CMP2 && fired_r[6]
      && !ovf[tsel[6]] |-> !ch_set[6])
      else $error("mode 2 raised a second request");
   a_mode3_low_on_wrap: assert property (mode_of(ctrl_r[3]) == MODE_CMP3 && !upper_dbl[3]
      && ovf[tsel[3]] && !hit[3] |=> !cc_pin_out[3])
      else $error("mode 3 pin not cleared on overflow");
   a_input_only_pins: assert property (cc_pin_oe[27:24] == 4'h0 ##1 cc_pin_out[27:24] == 4'h0)
      else $error("input-only channel drives its pin");
   a_double_pair_toggle: assert property (mode_of(ctrl_r[4]) == MODE_DBL && hit[12]
      |=> cc_pin_out[4] != $past(cc_pin_out[4]))
      else $error("double mode partner match did not toggle");
   a_timer_wrap_flag: assert property (ovf[0] |=> st_tm_r[0])
      else $error("timer overflow flag not set");

   c_capture_seen: cover property (cap_ev[1] ##1 st_ch_r[1]);
   c_mode3_cycle: cover property (ch_set[3] && mode_of(ctrl_r[3]) == MODE_CMP3
      ##[1:1000] ovf[tsel[3]]);
   c_irq_raised: cover property (!irq ##1 irq);
   c_apb_error: cover property (pready && pslverr);
endmodule : ccu_top
`default_nettype wire

// ==== tb/ccu_pin_model.sv ====
/*
 Pin-side partner of the capture/compare unit: external pin levels and
 the three count sources. Assumes the bench sets lvl and req by
 non-blocking assignment right after a rising pclk edge.
*/
`timescale 1ns/1ns
`default_nettype none
module ccu_pin_model (
   // Clock
   input  wire logic        pclk,
   // Bench commands
   input  wire logic [31:0] lvl,
   input  wire logic [2:0]  req,
   // Channel pins
   input  wire logic [31:0] pin_out,
   input  wire logic [31:0] pin_oe,
   output logic      [31:0] pin_in,
   // Count sources
   output logic             ext_a,
   output logic             ext_b,
   output logic             gen_tick
);
   logic [2:0] pulse_q = 3'h0;

   // Unit's drive wins where it drives; elsewhere the outside level
   assign pin_in   = (pin_oe & pin_out) | (~pin_oe & lvl);
   assign ext_a    = pulse_q[0];
   assign ext_b    = pulse_q[1];
   assign gen_tick = pulse_q[2];

   // One-cycle pulses, as an overflow of general timer six would give
   always @(posedge pclk) begin
      pulse_q <= req;
   end
endmodule : ccu_pin_model
`default_nettype wire

// ==== tb/tb.sv ====
/*
 Self-checking bench for ccu_top: APB master tasks, pin partner,
 random counts and compare-mode corner cases. Assumes the ccu_pkg map.
*/
`timescale 1ns/1ns
`default_nettype none
module tb
   import ccu_pkg::*;
;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [31:0] pin_in;
   logic [31:0] pin_out;
   logic [31:0] pin_oe;
   logic [31:0] lvl = 32'h0;
   logic [2:0]  req = 3'h0;
   logic        ext_a;
   logic        ext_b;
   logic        gen_tick;
   logic        irq;
   logic [31:0] d;
   logic        e;
   logic [11:0] bad [3] = '{12'h118, 12'h150, 12'h002};
   int          num_errors = 0;
   int          samples_checked = 0;
   int          cycles = 0;

   always #25 pclk = ~pclk;

   ccu_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .cc_pin_in(pin_in), .cc_pin_out(pin_out),
      .cc_pin_oe(pin_oe), .array_a_timer_first_ext_in(ext_a),
      .array_b_timer_first_ext_in(ext_b), .general_timer_six_tick(gen_tick), .irq(irq));

   ccu_pin_model u_pins (.pclk(pclk), .lvl(lvl), .req(req), .pin_out(pin_out),
      .pin_oe(pin_oe), .pin_in(pin_in), .ext_a(ext_a), .ext_b(ext_b), .gen_tick(gen_tick));

   task automatic results();
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : results

   // Expected run is about 1200 cycles
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors++;
         $display("[FAIL] %0t run too long", $time);
         results();
      end
   end

   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %0t word %h expected %h", $time, got, exp);
      end
   endtask : chk_word

   task automatic chk_bit(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
      end
   endtask : chk_bit

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      // Only the bench timeout ends a stalled wait
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1);
      d = prdata;
      e = pslverr;
      chk_bit(n == 2, 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [31:0] v);
      apb(1'b1, a, v);
   endtask : wr

   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk_word(d, exp);
   endtask : rd

   task automatic pulse(input int src);
      req <= 3'(1 << src);
      @(posedge pclk);
      req <= 3'h0;
      repeat (2) @(posedge pclk);
   endtask : pulse

   task automatic wait_pin(input int ch, input logic l);
      int n;
      n = 0;
      while (pin_out[ch] !== l && n < 200) begin
         @(posedge pclk);
         n++;
      end
      chk_bit(pin_out[ch], l);
   endtask : wait_pin

   initial begin
      logic [15:0] v;
      logic [15:0] c;
      logic [31:0] w;
      int          m;
      int          lo;
      void'($urandom(32'h0CF812DC));
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      rd(OFS_CHAN_CTRL, 32'h0);
      rd(OFS_TMR_CNT, 32'h0);
      rd(OFS_EN_TM, 32'h0);
      wr(OFS_STAT_CH, 32'hFFFFFFFF);
      rd(OFS_STAT_CH, 32'h0);
      for (int i = 0; i < 3; i++) begin
         apb(1'b0, bad[i], 32'h0);
         chk_bit(e, 1'b1);
         chk_word(d, 32'h0);
      end
      w = $urandom;
      wr(OFS_CHAN_CTRL + 12'h50, w);
      rd(OFS_CHAN_CTRL + 12'h50, w & {20'h0, CTRL_MASK});
      wr(OFS_CHAN_CTRL + 12'h50, 32'h0);
      $display("test registers done");
      for (int t = 0; t < 4; t++) begin
         m = $urandom_range(5, 1);
         wr(OFS_TMR_CTRL + 12'(4 * t), (t % 2 == 0) ? 32'h18 : 32'h17);
         wr(OFS_TMR_CNT + 12'(4 * t), 32'h0);
         repeat (m) pulse((t % 2 == 0) ? t / 2 : 2);
         repeat (4) @(posedge pclk);
         rd(OFS_TMR_CNT + 12'(4 * t), 32'(m));
         wr(OFS_TMR_CTRL + 12'(4 * t), 32'h0);
      end
      for (int s = 0; s < 2; s++) begin
         wr(OFS_TMR_CTRL + 12'h4, 32'h10 | s);
         wr(OFS_TMR_CNT + 12'h4, 32'h0);
         repeat (190) @(posedge pclk);
         apb(1'b0, OFS_TMR_CNT + 12'h4, 32'h0);
         lo = 184 / (8 << s);
         chk_bit(d >= lo && d <= lo + 2, 1'b1);
      end
      wr(OFS_TMR_CTRL + 12'h4, 32'h0);
      $display("test timers done");
      wr(OFS_EN_CH, 32'h40);
      for (int i = 0; i < 2; i++) begin
         wr(OFS_CHAN_CTRL + 12'h18, {29'h0, (i == 1) ? MODE_CMP2 : MODE_CMP0});
         wr(OFS_VALUE + 12'h18, 32'h0102);
         wr(OFS_TMR_CNT, 32'h0100);
         wr(OFS_TMR_CTRL, 32'h10);
         repeat (40) @(posedge pclk);
         chk_bit(irq, 1'b1);
         rd(OFS_STAT_CH, 32'h40);
         wr(OFS_CLR_CH, 32'h40);
         // Rewind without overflow: same timer period
         wr(OFS_TMR_CNT, 32'h0100);
         repeat (40) @(posedge pclk);
         chk_bit(irq, i == 0);
         wr(OFS_TMR_CTRL, 32'h0);
         wr(OFS_CLR_CH, 32'h40);
      end
      wr(OFS_EN_CH, 32'h0);
      wr(OFS_CHAN_CTRL + 12'h18, 32'h0);
      $display("test compare irq done");
      wr(OFS_CHAN_CTRL + 12'h08, {29'h0, MODE_CMP1});
      wr(OFS_CHAN_CTRL + 12'h60, {29'h0, MODE_CMP1});
      wr(OFS_VALUE + 12'h08, 32'h0202);
      wr(OFS_TMR_CNT, 32'h0200);
      wr(OFS_TMR_CTRL, 32'h10);
      wait_pin(2, 1'b1);
      chk_bit(pin_oe[2], 1'b1);
      chk_bit(pin_oe[24], 1'b0);
      wr(OFS_TMR_CNT, 32'h0200);
      wait_pin(2, 1'b0);
      wr(OFS_CHAN_CTRL + 12'h10, {29'h0, MODE_DBL});
      wr(OFS_VALUE + 12'h10, 32'h0302);
      wr(OFS_VALUE + 12'h30, 32'h0305);
      wr(OFS_TMR_CNT, 32'h0300);
      wait_pin(4, 1'b1);
      wait_pin(4, 1'b0);
      $display("test toggle done");
      wr(OFS_CHAN_CTRL + 12'h0C, {29'h0, MODE_CMP3});
      wr(OFS_VALUE + 12'h0C, 32'hFFFE);
      wr(OFS_TMR_RELD, 32'hFFFC);
      wr(OFS_TMR_CNT, 32'hFFFD);
      wait_pin(3, 1'b1);
      wait_pin(3, 1'b0);
      chk_bit(irq, 1'b0);
      rd(OFS_STAT_TM, 32'h1);
      wr(OFS_EN_TM, 32'h1);
      repeat (3) @(posedge pclk);
      chk_bit(irq, 1'b1);
      wr(OFS_TMR_CTRL, 32'h0);
      wr(OFS_CLR_TM, 32'h1);
      repeat (3) @(posedge pclk);
      chk_bit(irq, 1'b0);
      $display("test mode3 done");
      v = 16'h0;
      for (int em = 1; em < 4; em++) begin
         // Edge kinds 2 and 3 capture from the second timer of the pair
         wr(OFS_CHAN_CTRL + 12'h04, {26'h0, em[1:0], em[1], MODE_CAPT});
         for (int k = 0; k < 2; k++) begin
            c = 16'($urandom);
            wr(OFS_TMR_CNT, {16'h0, c});
            wr(OFS_TMR_CNT + 12'h4, {16'h0, ~c});
            wr(OFS_CLR_CH, 32'hFFFFFFFF);
            lvl[1] <= (k == 0);
            repeat (3) @(posedge pclk);
            if (em[k]) v = em[1] ? ~c : c;
            rd(OFS_STAT_CH, {30'h0, em[k], 1'b0});
            rd(OFS_VALUE + 12'h04, {16'h0, v});
         end
      end
      $display("test capture done");
      results();
   end
endmodule : tb
`default_nettype wire
